// File: hdl/rso_pkg.sv
// Overview of operation
// - Guaranteed soak has an off/on setting; off counts soak time unconditionally.
// - With guaranteed soak on, soak counts only while measured value is inside band.
// - In-band soak time accumulates across interruptions; step advances when total reached.
// - Band test uses the programmed step setpoint, not the limited setpoint.
// - Measured-value start searches program for first matching point on entering run.
// - Measured value equal to a step setpoint starts in that step's soak.
// - Measured value inside a ramp's span enters that ramp partway.
// - No match and below program: ramp from measured value to first target.
// - No match and above program, or over range: soak of largest setpoint step.
// - Under range at run: soak of smallest setpoint step.
// - Measured-value start is ignored while power-restore mode is continue.
// - Reset power-restore mode leaves the sequencer stopped after power returns.
// - Continue mode resumes from saved state, saved at most five minutes earlier.
// - Initial power-restore mode restarts the program at its first step.
// - Maximum and minimum pattern bounds take 0 to 30 or input selection.
// - Input-selected pattern follows pattern thirty in the stepping order.
// - Program command takes stop, run and hold; run again releases hold.
// - A distinct status shows guaranteed soak active with value outside band.
package rso_pkg;
	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_BAND    = 8'h04;
	localparam logic [7:0] ADDR_PATTERN = 8'h08;
	localparam logic [7:0] ADDR_INDEX   = 8'h0C;
	localparam logic [7:0] ADDR_STEP_SV = 8'h10;
	localparam logic [7:0] ADDR_TIMES   = 8'h14;
	localparam logic [7:0] ADDR_STATUS  = 8'h18;
	localparam logic [7:0] ADDR_LIMIT   = 8'h1C;

	localparam logic [1:0] CMD_STOP = 2'h0;
	localparam logic [1:0] CMD_RUN  = 2'h1;
	localparam logic [1:0] CMD_HOLD = 2'h2;

	localparam logic [1:0] RESTORE_STOPPED  = 2'h0;
	localparam logic [1:0] RESTORE_CONTINUE = 2'h1;
	localparam logic [1:0] RESTORE_INITIAL  = 2'h2;

	localparam logic [4:0] PAT_LAST_FIXED         = 5'h1E;
	localparam logic [4:0] input_selected_pattern = 5'h1F;

	localparam logic [15:0] BAND_MAX     = 16'h7FFF;
	localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
	localparam logic [4:0]  PAT_MIN_RST  = 5'h00;
	localparam logic [4:0]  PAT_MAX_RST  = 5'h1E;
	localparam logic [15:0] LIM_HI_RST   = 16'hFFFF;
	localparam logic [15:0] LIM_LO_RST   = 16'h0000;

	localparam int CLK_NS        = 20;
	localparam int TICK_MS       = 1000;
	localparam int TICK_CYCLES   = TICK_MS * 1000000 / CLK_NS;
	localparam int SAVE_MINUTES  = 5;
	localparam int TICK_PER_MIN  = 60000 / TICK_MS;
	localparam logic [15:0] SAVE_TICKS = 16'(SAVE_MINUTES * TICK_PER_MIN);

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_SEARCH = 3'b001,
		ST_RAMP   = 3'b010,
		ST_SOAK   = 3'b011,
		ST_END    = 3'b100
	} rso_state_t;

	typedef struct packed {
		logic [15:0] sv;
		logic [15:0] ramp;
		logic [15:0] soak;
	} rso_step_t;

	typedef struct packed {
		rso_state_t  state;
		logic [5:0]  step;
		logic [15:0] elapsed;
		logic [15:0] ramp_from;
		logic [15:0] ramp_len;
		logic [15:0] soak_cnt;
	} rso_snap_t;
endpackage

// File: hdl/rso_seq.sv
`timescale 1ns/100ps
module rso_seq #(
	parameter int TICK_CYC = rso_pkg::TICK_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [15:0] measured_value,
	input  wire logic        pv_over_range,
	input  wire logic        pv_under_range,
	input  wire logic        power_ok_pin,
	input  wire logic        key_pin,
	input  wire logic [4:0]  pattern_pins,
	output logic      [15:0] setpoint_out,
	output logic             out_of_band_status,
	output logic             program_end,
	output logic             program_hold
);
	rso_pkg::rso_step_t  tbl [64];
	logic [1:0]          program_command;
	logic [1:0]          cmd_prev;
	logic                soak_guard_en;
	logic                measured_value_start_enable;
	logic [1:0]          power_restore_mode;
	logic [15:0]         soak_band_upper;
	logic [15:0]         soak_band_lower;
	logic [4:0]          pattern_step_max;
	logic [4:0]          pattern_step_min;
	logic [4:0]          pattern_cur;
	logic [5:0]          tbl_index;
	logic [15:0]         lim_hi;
	logic [15:0]         lim_lo;
	logic [6:0]          sync1;
	logic [6:0]          sync2;
	logic [6:0]          sync3;
	logic [6:0]          filt;
	logic [6:0]          pin_vec;
	logic                key_prev;
	logic                pwr_prev;
	logic                key_event;
	logic                pwr_up;
	logic [31:0]         tick_cnt;
	logic                tick;
	logic [15:0]         save_cnt;
	rso_pkg::rso_state_t state;
	logic [5:0]          step;
	logic [15:0]         elapsed;
	logic [15:0]         ramp_from;
	logic [15:0]         ramp_len;
	logic [15:0]         soak_cnt;
	logic [15:0]         sp_raw;
	rso_pkg::rso_snap_t  snap;
	logic [5:0]          srch;
	logic [5:0]          max_step;
	logic [5:0]          min_step;
	logic [15:0]         max_sv;
	logic [15:0]         min_sv;
	logic [5:0]          first_step;
	logic [5:0]          last_step;
	logic [4:0]          eff_pat;
	logic                running;
	logic                in_band;
	logic                bus_setup;
	logic                bus_wr;
	logic [15:0]         cur_sv;
	logic [15:0]         prev_sv;

	// Ramp setpoint interpolated linearly from start value to step target.
	function automatic logic [15:0] ramp_point(input logic [15:0] from, input logic [15:0] to,
			input logic [15:0] el, input logic [15:0] len);
		logic signed [16:0] diff;
		logic signed [33:0] prod;
		logic signed [33:0] quo;
		diff = $signed({1'b0, to}) - $signed({1'b0, from});
		prod = diff * $signed({1'b0, el});
		quo = (len == 16'h0000) ? 34'sh0 : prod / $signed({18'h00000, len});
		ramp_point = 16'($signed({18'h00000, from}) + quo);
	endfunction

	// Remaining ramp time scaled to the part of the span still to go.
	function automatic logic [15:0] part_len(input logic [15:0] t, input logic [15:0] pv,
			input logic [15:0] to, input logic [15:0] from);
		logic [15:0] rest;
		logic [15:0] span;
		logic [31:0] prod;
		rest = (to > pv) ? to - pv : pv - to;
		span = (to > from) ? to - from : from - to;
		prod = t * rest;
		part_len = (span == 16'h0000) ? 16'h0000 : 16'(prod / {16'h0000, span});
	endfunction

	assign pin_vec   = {pattern_pins, key_pin, power_ok_pin};
	assign bus_setup = psel && !penable && !pready;
	assign bus_wr    = bus_setup && pwrite;
	assign running   = (program_command == rso_pkg::CMD_RUN) && filt[0];
	assign cur_sv    = tbl[step].sv;
	assign prev_sv   = tbl[srch - 6'h01].sv;

	// Pattern bound 31 means the pattern picked on the digital inputs.
	assign eff_pat = (pattern_cur == rso_pkg::input_selected_pattern) ?
		((filt[6:2] > rso_pkg::PAT_LAST_FIXED) ? rso_pkg::PAT_LAST_FIXED : filt[6:2]) : pattern_cur;

	always_comb
	begin
		if (eff_pat < 5'h10)
		begin
			first_step = {eff_pat[3:0], 2'b00};
			last_step  = {eff_pat[3:0], 2'b11};
		end
		else if (eff_pat < 5'h18)
		begin
			first_step = {eff_pat[2:0], 3'b000};
			last_step  = {eff_pat[2:0], 3'b111};
		end
		else if (eff_pat < 5'h1C)
		begin
			first_step = {eff_pat[1:0], 4'h0};
			last_step  = {eff_pat[1:0], 4'hF};
		end
		else if (eff_pat < 5'h1E)
		begin
			first_step = {eff_pat[0], 5'h00};
			last_step  = {eff_pat[0], 5'h1F};
		end
		else
		begin
			first_step = 6'h00;
			last_step  = 6'h3F;
		end
	end

	// Band is judged against the programmed step value so a clamped output cannot mask it.
	assign in_band = ({1'b0, measured_value} + {1'b0, soak_band_lower} >= {1'b0, cur_sv}) &&
		({1'b0, measured_value} <= {1'b0, cur_sv} + {1'b0, soak_band_upper});

	// Pins pass three flops; a change is taken only when the last two agree.
	genvar gi;
	generate
		for (gi = 0; gi < 7; gi++)
		begin : g_sync
			always_ff @(posedge clk)
			begin
				if (srst)
				begin
					sync1[gi] <= 1'b0;
					sync2[gi] <= 1'b0;
					sync3[gi] <= 1'b0;
					filt[gi]  <= 1'b0;
				end
				else
				begin
					sync1[gi] <= pin_vec[gi];
					sync2[gi] <= sync1[gi];
					sync3[gi] <= sync2[gi];
					if (sync2[gi] == sync3[gi])
						filt[gi] <= sync3[gi];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			key_prev <= 1'b0;
			pwr_prev <= 1'b0;
			key_event <= 1'b0;
			pwr_up <= 1'b0;
		end
		else
		begin
			key_prev <= filt[1];
			pwr_prev <= filt[0];
			key_event <= filt[1] && !key_prev;
			pwr_up <= filt[0] && !pwr_prev;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst || !running)
		begin
			tick_cnt <= 32'h0000_0000;
			tick <= 1'b0;
		end
		else
		begin
			tick <= (tick_cnt == 32'(TICK_CYC - 1));
			tick_cnt <= (tick_cnt == 32'(TICK_CYC - 1)) ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
		end
	end

	// Control word, band, limits and pattern bounds.
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			{power_restore_mode, measured_value_start_enable, soak_guard_en, program_command} <=
				rso_pkg::CTRL_RESET[5:0];
			soak_band_upper <= 16'h0000;
			soak_band_lower <= 16'h0000;
			pattern_step_min <= rso_pkg::PAT_MIN_RST;
			pattern_step_max <= rso_pkg::PAT_MAX_RST;
			pattern_cur <= rso_pkg::PAT_MIN_RST;
			tbl_index <= 6'h00;
			lim_hi <= rso_pkg::LIM_HI_RST;
			lim_lo <= rso_pkg::LIM_LO_RST;
		end
		else
		begin
			if (bus_wr && paddr == rso_pkg::ADDR_CTRL)
			begin
				if (pwdata[1:0] != 2'h3)
					program_command <= pwdata[1:0];
				soak_guard_en <= pwdata[2];
				measured_value_start_enable <= pwdata[3];
				if (program_command == rso_pkg::CMD_STOP && pwdata[5:4] != 2'h3)
					power_restore_mode <= pwdata[5:4];
			end
			if (pwr_up && power_restore_mode == rso_pkg::RESTORE_STOPPED)
				program_command <= rso_pkg::CMD_STOP;
			if (pwr_up && power_restore_mode == rso_pkg::RESTORE_INITIAL)
				program_command <= rso_pkg::CMD_RUN;
			if (bus_wr && paddr == rso_pkg::ADDR_BAND)
			begin
				soak_band_upper <= (pwdata[15:0] > rso_pkg::BAND_MAX) ? rso_pkg::BAND_MAX : pwdata[15:0];
				soak_band_lower <= (pwdata[31:16] > rso_pkg::BAND_MAX) ? rso_pkg::BAND_MAX : pwdata[31:16];
			end
			if (bus_wr && paddr == rso_pkg::ADDR_PATTERN)
			begin
				pattern_step_min <= pwdata[4:0];
				pattern_step_max <= pwdata[9:5];
				pattern_cur <= pwdata[14:10];
			end
			else if (key_event)
				pattern_cur <= (pattern_cur >= pattern_step_max) ? pattern_step_min :
					pattern_cur + 5'h01;
			if (bus_wr && paddr == rso_pkg::ADDR_INDEX)
				tbl_index <= pwdata[5:0];
			if (bus_wr && paddr == rso_pkg::ADDR_LIMIT)
				{lim_lo, lim_hi} <= pwdata;
		end
	end

	always_ff @(posedge clk)
	begin
		if (bus_wr && paddr == rso_pkg::ADDR_STEP_SV)
			tbl[tbl_index].sv <= pwdata[15:0];
		if (bus_wr && paddr == rso_pkg::ADDR_TIMES)
			{tbl[tbl_index].soak, tbl[tbl_index].ramp} <= pwdata;
	end

	// Saved state lags a power loss by no more than the save period.
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			save_cnt <= 16'h0000;
			snap <= '0;
		end
		else if (tick)
		begin
			save_cnt <= (save_cnt >= rso_pkg::SAVE_TICKS - 16'h0001) ? 16'h0000 : save_cnt + 16'h0001;
			if (save_cnt >= rso_pkg::SAVE_TICKS - 16'h0001)
				snap <= {state, step, elapsed, ramp_from, ramp_len, soak_cnt};
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			state <= rso_pkg::ST_IDLE;
			cmd_prev <= rso_pkg::CMD_STOP;
			{step, srch, max_step, min_step} <= 24'h00_0000;
			{elapsed, ramp_from, ramp_len, soak_cnt} <= 64'h0;
			max_sv <= 16'h0000;
			min_sv <= 16'hFFFF;
		end
		else
		begin
			cmd_prev <= program_command;
			if (pwr_up && power_restore_mode == rso_pkg::RESTORE_CONTINUE)
			begin
				state <= snap.state;
				{step, elapsed, ramp_from, ramp_len, soak_cnt} <= snap[69:0];
			end
			else if (pwr_up && power_restore_mode == rso_pkg::RESTORE_INITIAL)
			begin
				state <= rso_pkg::ST_RAMP;
				step <= first_step;
				{elapsed, soak_cnt} <= 32'h0;
				ramp_from <= measured_value;
				ramp_len <= tbl[first_step].ramp;
			end
			else if (program_command == rso_pkg::CMD_STOP)
				state <= rso_pkg::ST_IDLE;
			else if (program_command == rso_pkg::CMD_RUN && cmd_prev == rso_pkg::CMD_STOP)
			begin
				{elapsed, soak_cnt} <= 32'h0;
				max_sv <= 16'h0000;
				min_sv <= 16'hFFFF;
				srch <= first_step;
				if (measured_value_start_enable &&
					power_restore_mode != rso_pkg::RESTORE_CONTINUE)
					state <= rso_pkg::ST_SEARCH;
				else
				begin
					state <= rso_pkg::ST_RAMP;
					step <= first_step;
					ramp_from <= measured_value;
					ramp_len <= tbl[first_step].ramp;
				end
			end
			else if (state == rso_pkg::ST_SEARCH)
			begin
				if (tbl[srch].sv >= max_sv)
				begin
					max_sv <= tbl[srch].sv;
					max_step <= srch;
				end
				if (tbl[srch].sv < min_sv)
				begin
					min_sv <= tbl[srch].sv;
					min_step <= srch;
				end
				if (!pv_over_range && !pv_under_range && measured_value == tbl[srch].sv)
				begin
					state <= rso_pkg::ST_SOAK;
					step <= srch;
				end
				else if (!pv_over_range && !pv_under_range && srch != first_step &&
					((measured_value > prev_sv && measured_value < tbl[srch].sv) ||
					(measured_value < prev_sv && measured_value > tbl[srch].sv)))
				begin
					state <= rso_pkg::ST_RAMP;
					step <= srch;
					ramp_from <= measured_value;
					ramp_len <= part_len(tbl[srch].ramp, measured_value, tbl[srch].sv, prev_sv);
				end
				else if (srch == last_step)
				begin
					if (pv_under_range)
					begin
						state <= rso_pkg::ST_SOAK;
						step <= (tbl[srch].sv < min_sv) ? srch : min_step;
					end
					else if (pv_over_range || measured_value > max_sv || measured_value > tbl[srch].sv)
					begin
						state <= rso_pkg::ST_SOAK;
						step <= (tbl[srch].sv >= max_sv) ? srch : max_step;
					end
					else
					begin
						state <= rso_pkg::ST_RAMP;
						step <= first_step;
						ramp_from <= measured_value;
						ramp_len <= tbl[first_step].ramp;
					end
				end
				else
					srch <= srch + 6'h01;
			end
			else if (state == rso_pkg::ST_RAMP)
			begin
				if (elapsed >= ramp_len)
				begin
					state <= rso_pkg::ST_SOAK;
					soak_cnt <= 16'h0000;
				end
				else if (tick)
					elapsed <= elapsed + 16'h0001;
			end
			else if (state == rso_pkg::ST_SOAK)
			begin
				if (soak_cnt >= tbl[step].soak)
				begin
					elapsed <= 16'h0000;
					soak_cnt <= 16'h0000;
					ramp_from <= cur_sv;
					state <= (step == last_step) ? rso_pkg::ST_END : rso_pkg::ST_RAMP;
					step <= (step == last_step) ? step : step + 6'h01;
					ramp_len <= tbl[(step == last_step) ? step : step + 6'h01].ramp;
				end
				else if (tick && (!soak_guard_en || in_band))
					soak_cnt <= soak_cnt + 16'h0001;
			end
		end
	end

	assign sp_raw = (state == rso_pkg::ST_RAMP) ? ramp_point(ramp_from, cur_sv, elapsed, ramp_len) :
		cur_sv;

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			setpoint_out <= 16'h0000;
			out_of_band_status <= 1'b0;
			program_end <= 1'b0;
			program_hold <= 1'b0;
		end
		else
		begin
			setpoint_out <= (sp_raw > lim_hi) ? lim_hi : (sp_raw < lim_lo) ? lim_lo : sp_raw;
			out_of_band_status <= soak_guard_en && state == rso_pkg::ST_SOAK && !in_band;
			program_end <= state == rso_pkg::ST_END;
			program_hold <= program_command == rso_pkg::CMD_HOLD;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else
		begin
			pready <= bus_setup;
			pslverr <= bus_setup && paddr > rso_pkg::ADDR_LIMIT;
			if (bus_setup && !pwrite)
			begin
				case (paddr)
					rso_pkg::ADDR_CTRL: prdata <= {26'h0, power_restore_mode,
						measured_value_start_enable, soak_guard_en, program_command};
					rso_pkg::ADDR_BAND: prdata <= {soak_band_lower, soak_band_upper};
					rso_pkg::ADDR_PATTERN: prdata <= {17'h0, pattern_cur, pattern_step_max,
						pattern_step_min};
					rso_pkg::ADDR_INDEX: prdata <= {26'h0, tbl_index};
					rso_pkg::ADDR_STEP_SV: prdata <= {16'h0, tbl[tbl_index].sv};
					rso_pkg::ADDR_TIMES: prdata <= {tbl[tbl_index].soak, tbl[tbl_index].ramp};
					rso_pkg::ADDR_STATUS: prdata <= {soak_cnt, 5'h00, step, in_band,
						out_of_band_status, state};
					rso_pkg::ADDR_LIMIT: prdata <= {lim_lo, lim_hi};
					default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule

// File: verification/rso_seq_checker.sv
`timescale 1ns/100ps
module rso_seq_checker (
	input wire logic        clk,
	input wire logic        srst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [15:0] measured_value,
	input wire logic [15:0] setpoint_out,
	input wire logic        out_of_band_status,
	input wire logic        program_end,
	input wire logic        program_hold
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	AST_PREADY_PULSE: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("pready is not a single pulse after setup");
	AST_SLVERR_MAP: assert property (psel && !penable |=> pslverr == (paddr > rso_pkg::ADDR_LIMIT))
		else $error("pslverr does not match the address decode");
	AST_UNMAPPED_ZERO: assert property (pready && pslverr |-> prdata == 32'h0000_0000)
		else $error("refused access returned nonzero data");
	AST_HOLD_SET: assert property (
		psel && !penable && pwrite && paddr == rso_pkg::ADDR_CTRL
		&& pwdata[1:0] == rso_pkg::CMD_HOLD |-> ##[1:3] program_hold)
		else $error("hold command did not raise program_hold");
	AST_HOLD_RELEASE: assert property (
		psel && !penable && pwrite && paddr == rso_pkg::ADDR_CTRL
		&& pwdata[1:0] == rso_pkg::CMD_RUN |-> ##[1:3] !program_hold)
		else $error("run command did not release program_hold");
	AST_OOB_NOT_END: assert property (out_of_band_status |-> !program_end)
		else $error("out of band status shown after program end");
	AST_OOB_FREEZE: assert property (
		(out_of_band_status && $stable(measured_value))[*2] |=> !$rose(program_end))
		else $error("program ended while value was out of band");
	AST_HOLD_FREEZE: assert property (program_hold[*2] |=> !$rose(program_end))
		else $error("program ended while held");
	AST_RESET_QUIET: assert property (disable iff (1'b0) srst |=> setpoint_out == 16'h0000
		&& !program_end && !program_hold && !out_of_band_status)
		else $error("outputs not cleared by reset");
endmodule

bind rso_seq rso_seq_checker i_rso_seq_checker (.clk, .srst, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .measured_value, .setpoint_out,
	.out_of_band_status, .program_end, .program_hold);

// File: verification/rso_panel.sv
`timescale 1ns/100ps
module rso_panel (
	input  wire logic        clk,
	output logic      [15:0] measured_value,
	output logic             pv_over_range,
	output logic             pv_under_range,
	output logic             power_ok_pin,
	output logic             key_pin,
	output logic      [4:0]  pattern_pins
);
	initial
	begin
		measured_value = 16'h0000;
		pv_over_range  = 1'b0;
		pv_under_range = 1'b0;
		power_ok_pin   = 1'b1;
		key_pin        = 1'b0;
		pattern_pins   = 5'h05;
	end

	// The key is held well past the three-flop sync so one press counts once.
	task automatic press();
		key_pin <= 1'b1;
		repeat (8) @(posedge clk);
		key_pin <= 1'b0;
		repeat (8) @(posedge clk);
	endtask

	task automatic power_cycle();
		power_ok_pin <= 1'b0;
		repeat (20) @(posedge clk);
		power_ok_pin <= 1'b1;
		repeat (20) @(posedge clk);
	endtask

	task automatic set_pv(input logic [15:0] v, input logic ovr, input logic und);
		measured_value <= v;
		pv_over_range  <= ovr;
		pv_under_range <= und;
		@(posedge clk);
	endtask
endmodule

// File: verification/rso_seq_tb_top.sv
`timescale 1ns/100ps
module rso_seq_tb_top;
	logic        clk;
	logic        srst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [15:0] measured_value;
	logic        pv_over_range;
	logic        pv_under_range;
	logic        power_ok_pin;
	logic        key_pin;
	logic [4:0]  pattern_pins;
	logic [15:0] setpoint_out;
	logic        out_of_band_status;
	logic        program_end;
	logic        program_hold;
	int          mismatches = 0;
	int          checks = 0;
	int          cycles = 0;
	logic [31:0] rd;
	logic        err;

	rso_seq #(.TICK_CYC(4)) i_rso_seq (.clk, .srst, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .measured_value, .pv_over_range,
		.pv_under_range, .power_ok_pin, .key_pin, .pattern_pins, .setpoint_out,
		.out_of_band_status, .program_end, .program_hold);
	rso_panel i_rso_panel (.clk, .measured_value, .pv_over_range, .pv_under_range,
		.power_ok_pin, .key_pin, .pattern_pins);

	initial clk = 1'b0;
	always #10 clk = ~clk;

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			wrap_up();
		end
	end

	// An idle cycle follows each transfer so psel is never assigned twice in one step.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Only the bench timeout ends this wait, so a dead slave is counted as a failure.
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	function automatic logic [31:0] cw(input logic [1:0] md, input logic mv, input logic gs,
		input logic [1:0] cmd);
		return {26'h0, md, mv, gs, cmd};
	endfunction

	task automatic step(input logic [5:0] i, input logic [15:0] sv, input logic [15:0] rt,
		input logic [15:0] st);
		apb(1'b1, rso_pkg::ADDR_INDEX, {26'h0, i});
		apb(1'b1, rso_pkg::ADDR_STEP_SV, {16'h0, sv});
		apb(1'b1, rso_pkg::ADDR_TIMES, {st, rt});
	endtask

	task automatic wait_end(input int lim);
		int n = 0;
		while (program_end !== 1'b1 && n < lim)
		begin
			@(posedge clk);
			n++;
		end
	endtask

	task automatic ctl(input logic [1:0] md, input logic mv, input logic gs, input logic [1:0] c);
		apb(1'b1, rso_pkg::ADDR_CTRL, cw(md, mv, gs, c));
	endtask

	task automatic t_regs();
		apb(1'b0, rso_pkg::ADDR_PATTERN, 32'h0);
		chk("pattern", {17'h0, 5'h00, rso_pkg::PAT_MAX_RST, rso_pkg::PAT_MIN_RST}, rd);
		apb(1'b0, rso_pkg::ADDR_LIMIT, 32'h0);
		chk("limit", {rso_pkg::LIM_LO_RST, rso_pkg::LIM_HI_RST}, rd);
		apb(1'b1, rso_pkg::ADDR_BAND, 32'hFFFF_FFFF);
		apb(1'b0, rso_pkg::ADDR_BAND, 32'h0);
		chk("band", {rso_pkg::BAND_MAX, rso_pkg::BAND_MAX}, rd);
		apb(1'b0, 8'h20, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, err});
		chk("unmapped data", 32'h0, rd);
	endtask

	task automatic t_keys();
		apb(1'b1, rso_pkg::ADDR_PATTERN, {17'h0, 5'h1C, rso_pkg::input_selected_pattern, 5'h1C});
		for (int k = 1; k <= 4; k++)
		begin
			i_rso_panel.press();
			apb(1'b0, rso_pkg::ADDR_PATTERN, 32'h0);
			chk("key pattern", (k == 4) ? 32'h1C : 32'h1C + k, {27'h0, rd[14:10]});
		end
		// Back to pattern 0 so the later scenarios run only the programmed steps 0 to 3.
		apb(1'b1, rso_pkg::ADDR_PATTERN, {17'h0, 5'h00, rso_pkg::PAT_MAX_RST, 5'h00});
	endtask

	task automatic t_gsoak();
		step(6'h00, 16'h0064, 16'h0000, 16'h0008);
		for (int i = 1; i < 4; i++)
			step(6'(i), 16'h0064, 16'h0000, 16'h0000);
		apb(1'b1, rso_pkg::ADDR_LIMIT, 32'h0000_0032);
		apb(1'b1, rso_pkg::ADDR_BAND, 32'h0005_0005);
		i_rso_panel.set_pv(16'h00C8, 1'b0, 1'b0);
		ctl(rso_pkg::RESTORE_STOPPED, 1'b0, 1'b1, rso_pkg::CMD_RUN);
		repeat (12) @(posedge clk);
		chk("out of band", 32'h1, {31'h0, out_of_band_status});
		chk("clamped setpoint", 32'h32, {16'h0, setpoint_out});
		repeat (60) @(posedge clk);
		chk("end while out", 32'h0, {31'h0, program_end});
		i_rso_panel.set_pv(16'h0064, 1'b0, 1'b0);
		repeat (16) @(posedge clk);
		i_rso_panel.set_pv(16'h00C8, 1'b0, 1'b0);
		repeat (40) @(posedge clk);
		chk("end after break", 32'h0, {31'h0, program_end});
		i_rso_panel.set_pv(16'h0064, 1'b0, 1'b0);
		wait_end(26);
		chk("end accumulated", 32'h1, {31'h0, program_end});
		ctl(rso_pkg::RESTORE_STOPPED, 1'b0, 1'b0, rso_pkg::CMD_STOP);
		i_rso_panel.set_pv(16'h00C8, 1'b0, 1'b0);
		ctl(rso_pkg::RESTORE_STOPPED, 1'b0, 1'b0, rso_pkg::CMD_RUN);
		wait_end(48);
		chk("end ungated", 32'h1, {31'h0, program_end});
		ctl(rso_pkg::RESTORE_STOPPED, 1'b0, 1'b0, rso_pkg::CMD_STOP);
	endtask

	task automatic t_search();
		logic [15:0] pv [7] = '{16'h0064, 16'h00FA, 16'h0032, 16'h01F4, 16'h0096, 16'h0096, 16'h00FA};
		logic [1:0]  fl [7] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h1, 2'h0};
		logic [8:0]  ex [7] = '{9'h003, 9'h012, 9'h002, 9'h01B, 9'h01B, 9'h003, 9'h002};
		logic [1:0]  md;
		for (int i = 0; i < 4; i++)
			step(6'(i), 16'(100 * (i + 1)), 16'h000A, 16'h0032);
		for (int i = 0; i < 7; i++)
		begin
			md = (i == 6) ? rso_pkg::RESTORE_CONTINUE : rso_pkg::RESTORE_STOPPED;
			i_rso_panel.set_pv(pv[i], fl[i][1], fl[i][0]);
			ctl(md, 1'b1, 1'b0, rso_pkg::CMD_STOP);
			ctl(md, 1'b1, 1'b0, rso_pkg::CMD_RUN);
			repeat (12) @(posedge clk);
			apb(1'b0, rso_pkg::ADDR_STATUS, 32'h0);
			chk("start point", {23'h0, ex[i]}, {23'h0, rd[10:5], rd[2:0]});
		end
		ctl(rso_pkg::RESTORE_CONTINUE, 1'b0, 1'b0, rso_pkg::CMD_HOLD);
		chk("hold flag", 32'h1, {31'h0, program_hold});
		ctl(rso_pkg::RESTORE_CONTINUE, 1'b0, 1'b0, rso_pkg::CMD_RUN);
		chk("hold released", 32'h0, {31'h0, program_hold});
		ctl(rso_pkg::RESTORE_CONTINUE, 1'b0, 1'b0, rso_pkg::CMD_STOP);
	endtask

	task automatic t_power();
		step(6'h00, 16'h0064, 16'h0014, 16'h03E8);
		i_rso_panel.set_pv(16'h0064, 1'b0, 1'b0);
		ctl(rso_pkg::RESTORE_STOPPED, 1'b0, 1'b0, rso_pkg::CMD_STOP);
		ctl(rso_pkg::RESTORE_STOPPED, 1'b0, 1'b0, rso_pkg::CMD_RUN);
		repeat (20) @(posedge clk);
		i_rso_panel.power_cycle();
		apb(1'b0, rso_pkg::ADDR_STATUS, 32'h0);
		chk("stopped restore", 32'h0, {29'h0, rd[2:0]});
		ctl(rso_pkg::RESTORE_INITIAL, 1'b0, 1'b0, rso_pkg::CMD_STOP);
		ctl(rso_pkg::RESTORE_INITIAL, 1'b0, 1'b0, rso_pkg::CMD_RUN);
		repeat (120) @(posedge clk);
		i_rso_panel.power_cycle();
		apb(1'b0, rso_pkg::ADDR_STATUS, 32'h0);
		chk("initial restore", 32'h002, {23'h0, rd[10:5], rd[2:0]});
		ctl(rso_pkg::RESTORE_CONTINUE, 1'b0, 1'b0, rso_pkg::CMD_STOP);
		ctl(rso_pkg::RESTORE_CONTINUE, 1'b0, 1'b0, rso_pkg::CMD_RUN);
		repeat (1300) @(posedge clk);
		i_rso_panel.power_cycle();
		apb(1'b0, rso_pkg::ADDR_STATUS, 32'h0);
		chk("continue restore", 32'h003, {23'h0, rd[10:5], rd[2:0]});
		ctl(rso_pkg::RESTORE_CONTINUE, 1'b0, 1'b0, rso_pkg::CMD_STOP);
	endtask

	initial
	begin
		srst    = 1'b1;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0;
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		repeat (6) @(posedge clk);
		t_regs();
		t_keys();
		t_gsoak();
		t_search();
		t_power();
		wrap_up();
	end
endmodule
